// File: hw/uda_arbiter.sv
// DMA bus arbiter with its Wishbone setting and status registers
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "uda_map.svh"
module uda_arbiter #(
	parameter int N_CH = 4,
	parameter int PW   = 2
) (
	input  wire logic                  mclk,      // Bus clock, 100 MHz
	input  wire logic                  reset,     // Asynchronous reset, active high
	input  wire logic                  ce,        // Clock enable, freezes state when low
	input  wire uda_pkg::uda_wb_req_t  wb_req,    // Wishbone request
	output uda_pkg::uda_wb_rsp_t       wb_rsp,    // Wishbone answer
	input  wire uda_pkg::uda_chan_req_t write_dma_channel_zero, // Write DMA request
	input  wire uda_pkg::uda_chan_req_t read_dma_channel_zero,  // Read DMA request
	output logic                       write_ch0_grant, // Bus granted to write DMA
	output logic                       read_ch0_grant,  // Bus granted to read DMA
	output logic                       bus_enabled      // Arbiter enable bit
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	uda_pkg::uda_setting_t set_q;
	uda_pkg::uda_setting_t set_d;
	uda_pkg::uda_state_t   state_q;
	logic [N_CH-1:0]       gnt_q;
	logic [1:0]            last_q;
	logic [1:0]            owner_q;
	logic                  refused_q;
	logic                  refused_d;
	logic                  ack_q;
	logic [31:0]           rdat_q;
	logic                  access;
	logic                  wr_en;
	logic [31:0]           cur_word;
	logic [31:0]           wr_word;
	logic [31:0]           status_word;
	logic [N_CH-1:0]       req_vec;
	logic [N_CH-1:0]       done_vec;
	logic [N_CH*PW-1:0]    pri_vec;
	logic                  pick_valid;
	logic [1:0]            pick_win;
	logic                  cur_distinct;
	logic                  owner_done;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// True when no two priority fields match
	function automatic logic all_distinct(input uda_pkg::uda_setting_t s);
		logic ok;
		ok = (s.write_ch1_priority != s.write_ch0_priority) &&
		     (s.write_ch1_priority != s.read_ch1_priority) &&
		     (s.write_ch1_priority != s.read_ch0_priority) &&
		     (s.write_ch0_priority != s.read_ch1_priority) &&
		     (s.write_ch0_priority != s.read_ch0_priority) &&
		     (s.read_ch1_priority  != s.read_ch0_priority);
		return ok;
	endfunction

	// Setting fields packed into the bus word, reserved bits zero
	function automatic logic [31:0] to_word(input uda_pkg::uda_setting_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`UDA_EN_BIT]                 = s.en;
		w[`UDA_MODE_BIT]               = s.fixed_mode;
		w[`UDA_PRI_W1_LSB +: 2]        = s.write_ch1_priority;
		w[`UDA_PRI_W0_LSB +: 2]        = s.write_ch0_priority;
		w[`UDA_PRI_R1_LSB +: 2]        = s.read_ch1_priority;
		w[`UDA_PRI_R0_LSB +: 2]        = s.read_ch0_priority;
		return w;
	endfunction

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------

	// A request is taken on the edge where ack is still low and ack
	// rises from that edge, so the master sees it one cycle later.
	// Gating with ack_q keeps a held strobe from being taken twice.
	// One wait state: the request is taken when ack is not yet up
	assign access   = wb_req.cyc && wb_req.stb && !ack_q;
	assign wr_en    = access && wb_req.we && (wb_req.adr == `UDA_SETTING_OFS);
	assign cur_word = to_word(set_q);

	// Byte lanes merge the write data into the current word
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wr_word[b*8 +: 8] = wb_req.sel[b] ? wb_req.dat[b*8 +: 8] : cur_word[b*8 +: 8];
		end
	end

	// ----------------------------------------------------------------
	// Setting register next value
	// ----------------------------------------------------------------

	// Mode and priorities only move while the arbiter is off, so a live
	// grant never sees its ranking change under it. While enabled a write
	// can only clear or keep the enable bit.
	// Fields lock while enabled; enable only rises on distinct priorities
	always_comb begin
		set_d     = set_q;
		refused_d = refused_q;
		if (wr_en) begin
			if (!set_q.en) begin
				set_d.fixed_mode         = wr_word[`UDA_MODE_BIT];
				set_d.write_ch1_priority = wr_word[`UDA_PRI_W1_LSB +: 2];
				set_d.write_ch0_priority = wr_word[`UDA_PRI_W0_LSB +: 2];
				set_d.read_ch1_priority  = wr_word[`UDA_PRI_R1_LSB +: 2];
				set_d.read_ch0_priority  = wr_word[`UDA_PRI_R0_LSB +: 2];
				// The check sees the fields as written in this same access
				set_d.en  = wr_word[`UDA_EN_BIT] && all_distinct(set_d);
				refused_d = wr_word[`UDA_EN_BIT] && !all_distinct(set_d);
			end else begin
				set_d.en  = wr_word[`UDA_EN_BIT];
				refused_d = 1'b0;
			end
		end
	end

	// Reset word split into its fields, so the reset branch assigns
	// constants of the exact field widths and drops no bits silently
	localparam logic [31:0] SET_RST_WORD = `UDA_SETTING_RST;
	localparam uda_pkg::uda_setting_t SET_RST = '{
		en:                 SET_RST_WORD[`UDA_EN_BIT],
		fixed_mode:         SET_RST_WORD[`UDA_MODE_BIT],
		write_ch1_priority: SET_RST_WORD[`UDA_PRI_W1_LSB +: 2],
		write_ch0_priority: SET_RST_WORD[`UDA_PRI_W0_LSB +: 2],
		read_ch1_priority:  SET_RST_WORD[`UDA_PRI_R1_LSB +: 2],
		read_ch0_priority:  SET_RST_WORD[`UDA_PRI_R0_LSB +: 2]
	};

	// Setting register
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			set_q <= SET_RST;
		end else if (ce) begin
			set_q <= set_d;
		end
	end

	// Software that polls enable after a refused write can tell a refusal
	// from a slow bus by this flag; it has one source, so no set/clear race.
	// Sticky note of the last refused enable, cleared by a good write
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			refused_q <= 1'b0;
		end else if (ce) begin
			refused_q <= refused_d;
		end
	end

	// ----------------------------------------------------------------
	// Bus answer
	// ----------------------------------------------------------------

	assign cur_distinct = all_distinct(set_q);

	// Bits 3-0 one-hot grant in channel index order, 5-4 last owner,
	// 8 priorities distinct, 9 bus owned, 10 last enable refused.
	// The distinct bit lets software check a setting before enabling.
	// All other bits read as zero.
	// Status word shows grant, last owner and check result
	always_comb begin
		status_word                                   = 32'h0000_0000;
		status_word[`UDA_ST_GNT_LSB +: 4]             = gnt_q;
		status_word[`UDA_ST_LAST_LSB +: 2]            = last_q;
		status_word[`UDA_ST_DIST_BIT]                 = cur_distinct;
		status_word[`UDA_ST_BUSY_BIT]                 = (state_q == uda_pkg::UDA_OWNED);
		status_word[`UDA_ST_REFUSE_BIT]               = refused_q;
	end

	// Registered ack costs a cycle per access but keeps the bus answer
	// free of any combinational path from the request.
	// Ack drops the cycle after it rises, so back-to-back needs a gap
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ack_q <= 1'b0;
		end else if (ce) begin
			ack_q <= access;
		end
	end

	// Read data captured with the ack; unmapped reads give zero
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rdat_q <= 32'h0000_0000;
		end else if (ce) begin
			if (access && !wb_req.we) begin
				unique case (wb_req.adr)
					`UDA_SETTING_OFS: rdat_q <= cur_word;
					`UDA_STATUS_OFS:  rdat_q <= status_word;
					default:          rdat_q <= 32'h0000_0000;
				endcase
			end else if (access) begin
				rdat_q <= 32'h0000_0000;
			end
		end
	end

	assign wb_rsp.ack = ack_q;
	assign wb_rsp.dat = rdat_q;

	// ----------------------------------------------------------------
	// Requests and winner selection
	// ----------------------------------------------------------------

	// Channel 1 slots stay in the vectors so that the pick logic and
	// the status word keep one index order for all four channels.
	// Channel 1 of each direction does not exist and never asks
	always_comb begin
		req_vec              = '0;
		done_vec             = '0;
		req_vec[`UDA_CH_W0]  = write_dma_channel_zero.req;
		req_vec[`UDA_CH_R0]  = read_dma_channel_zero.req;
		done_vec[`UDA_CH_W0] = write_dma_channel_zero.done;
		done_vec[`UDA_CH_R0] = read_dma_channel_zero.done;
	end

	// Priority vector in channel index order
	always_comb begin
		pri_vec                       = '0;
		pri_vec[`UDA_CH_W0*PW +: PW]  = set_q.write_ch0_priority;
		pri_vec[`UDA_CH_W1*PW +: PW]  = set_q.write_ch1_priority;
		pri_vec[`UDA_CH_R0*PW +: PW]  = set_q.read_ch0_priority;
		pri_vec[`UDA_CH_R1*PW +: PW]  = set_q.read_ch1_priority;
	end

	// Winner search for both modes
	uda_pick #(
		.N  (N_CH),
		.PW (PW),
		.IW (2)
	) u_pick (
		.req        (req_vec),
		.pri        (pri_vec),
		.fixed_mode (set_q.fixed_mode),
		.last       (last_q),
		.valid      (pick_valid),
		.win        (pick_win)
	);

	// Withdrawal counts as completion so a channel that gives up the bus
	// without a done pulse cannot hold the grant for ever.
	// The owner finishes on done or by withdrawing its request
	assign owner_done = done_vec[owner_q] || !req_vec[owner_q];

	// ----------------------------------------------------------------
	// Grant state machine
	// ----------------------------------------------------------------

	// A winner is picked on an idle edge and holds the grant until it is
	// done or withdraws; the grant then falls on that edge and the next
	// pick waits for the following edge, which leaves one idle cycle.
	// Clearing enable also ends ownership, one edge after the write.
	// One owner at a time; disabling takes the bus away one edge after the write
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q <= uda_pkg::UDA_IDLE;
			gnt_q   <= '0;
			owner_q <= 2'd0;
		end else if (ce) begin
			unique case (state_q)
				uda_pkg::UDA_IDLE: begin
					if (set_q.en && pick_valid) begin
						state_q <= uda_pkg::UDA_OWNED;
						gnt_q   <= N_CH'(1) << pick_win;
						owner_q <= pick_win;
					end
				end
				uda_pkg::UDA_OWNED: begin
					if (!set_q.en || owner_done) begin
						state_q <= uda_pkg::UDA_IDLE;
						gnt_q   <= '0;
					end
				end
			endcase
		end
	end

	// A grant cut short by clearing enable leaves the pointer alone, so
	// that owner keeps its turn when arbitration is switched back on.
	// Reset points at the last index so write channel 0 comes first.
	// Round-robin pointer moves only when an access completes
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			last_q <= `UDA_CH_R1;
		end else if (ce) begin
			if (state_q == uda_pkg::UDA_OWNED && owner_done) begin
				last_q <= owner_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// Grants and enable leave straight from flip-flops, so the far side
	// sees no glitch while the pick logic settles.
	assign write_ch0_grant = gnt_q[`UDA_CH_W0];
	assign read_ch0_grant  = gnt_q[`UDA_CH_R0];
	assign bus_enabled     = set_q.en;

endmodule

// File: hw/uda_map.svh
// Register map, field positions, reset values and channel indices of the DMA bus arbiter
`ifndef UDA_MAP_SVH
`define UDA_MAP_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define UDA_ADR_W         8
`define UDA_SETTING_OFS   8'h00
`define UDA_STATUS_OFS    8'h04

// ----------------------------------------------------------------
// Setting register fields
// ----------------------------------------------------------------
`define UDA_EN_BIT        31
`define UDA_MODE_BIT      28
`define UDA_PRI_W1_LSB    12
`define UDA_PRI_W0_LSB    8
`define UDA_PRI_R1_LSB    4
`define UDA_PRI_R0_LSB    0
`define UDA_SETTING_RST   32'h0000_0000

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define UDA_ST_GNT_LSB    0
`define UDA_ST_LAST_LSB   4
`define UDA_ST_DIST_BIT   8
`define UDA_ST_BUSY_BIT   9
`define UDA_ST_REFUSE_BIT 10

// ----------------------------------------------------------------
// Channel indices
// ----------------------------------------------------------------
`define UDA_CH_W0         2'd0
`define UDA_CH_W1         2'd1
`define UDA_CH_R0         2'd2
`define UDA_CH_R1         2'd3

`endif

// File: hw/uda_pkg.sv
// Types shared by the DMA bus arbiter files
package uda_pkg;

	// Programmed arbiter setting
	typedef struct packed {
		logic       en;
		logic       fixed_mode;
		logic [1:0] write_ch1_priority;
		logic [1:0] write_ch0_priority;
		logic [1:0] read_ch1_priority;
		logic [1:0] read_ch0_priority;
	} uda_setting_t;

	// Wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} uda_wb_req_t;

	// Wishbone answer from this slave
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} uda_wb_rsp_t;

	// One DMA channel asking for the system bus
	typedef struct packed {
		logic req;
		logic done;
	} uda_chan_req_t;

	// Arbiter states
	typedef enum logic [0:0] {
		UDA_IDLE,
		UDA_OWNED
	} uda_state_t;

endpackage

// File: hw/uda_pick.sv
// Combinational winner selection for round-robin and fixed-priority modes
`timescale 1ns/1ps
module uda_pick #(
	parameter int N  = 4,
	parameter int PW = 2,
	parameter int IW = 2
) (
	input  wire logic [N-1:0]    req,        // Live requests
	input  wire logic [N*PW-1:0] pri,        // Priority per channel, index order
	input  wire logic            fixed_mode, // 1 selects fixed priority
	input  wire logic [IW-1:0]   last,       // Channel whose access completed last
	output logic                 valid,      // Some channel requests
	output logic [IW-1:0]        win         // Index of the winner
);

	// Scan all channels; ties in fixed mode go to the lower index
	always_comb begin
		logic [IW-1:0] idx;
		logic [PW-1:0] best;
		logic          found;
		idx   = '0;
		best  = '1;
		found = 1'b0;
		win   = '0;
		for (int i = 1; i <= N; i++) begin
			idx = IW'((int'(last) + i) % N);
			if (!fixed_mode && req[idx] && !found) begin
				win   = idx;
				found = 1'b1;
			end
		end
		if (fixed_mode) begin
			for (int i = 0; i < N; i++) begin
				if (req[i] && (!found || pri[i*PW +: PW] < best)) begin
					win   = IW'(i);
					best  = pri[i*PW +: PW];
					found = 1'b1;
				end
			end
		end
		valid = found;
	end

endmodule

// File: bench/uda_arbiter_checker.sv
// Port checks of the DMA bus arbiter
`timescale 1ns/1ps
`include "uda_map.svh"
module uda_arbiter_checker (
	input wire logic                   mclk,    // Bus clock
	input wire logic                   reset,   // Async reset
	input wire logic                   ce,      // Clock enable
	input wire uda_pkg::uda_wb_req_t   wb_req,  // Bus request
	input wire uda_pkg::uda_wb_rsp_t   wb_rsp,  // Bus answer
	input wire uda_pkg::uda_chan_req_t write_dma_channel_zero, // Write DMA
	input wire uda_pkg::uda_chan_req_t read_dma_channel_zero,  // Read DMA
	input wire logic                   write_ch0_grant, // Write grant
	input wire logic                   read_ch0_grant,  // Read grant
	input wire logic                   bus_enabled      // Enable bit
);
	// ------
	// Helpers
	// ------
	wire logic taken  = ce && wb_req.cyc && wb_req.stb && !wb_rsp.ack;
	wire logic set_wr = taken && wb_req.we && wb_req.adr == `UDA_SETTING_OFS && wb_req.sel[3];
	wire logic any_g  = write_ch0_grant || read_ch0_grant;
	wire logic reqs   = write_dma_channel_zero.req || read_dma_channel_zero.req;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_one_grant: assert property (!(write_ch0_grant && read_ch0_grant))
		else $error("two grants at once");
	a_off_no_grant: assert property (!bus_enabled && !$past(bus_enabled) |-> !any_g)
		else $error("grant while disabled");
	a_ack_latency: assert property (taken |=> wb_rsp.ack)
		else $error("ack not one cycle after request");
	a_ack_pulse: assert property (wb_rsp.ack && ce |=> !wb_rsp.ack)
		else $error("ack longer than one cycle");
	a_grant_cause: assert property ($rose(write_ch0_grant) |-> $past(write_dma_channel_zero.req)
		&& $past(bus_enabled))
		else $error("write grant without request");
	a_grant_answer: assert property (ce && bus_enabled && !any_g && reqs |=> any_g)
		else $error("idle request not granted");
	a_grant_release: assert property (ce && write_ch0_grant && write_dma_channel_zero.done
		|=> !write_ch0_grant)
		else $error("grant held after done");
	a_enable_refuse: assert property (set_wr && wb_req.sel == 4'hf && wb_req.dat[31]
		&& !bus_enabled && wb_req.dat[9:8] == wb_req.dat[1:0] |=> !bus_enabled)
		else $error("enable set with equal priorities");
	a_enable_clear: assert property (set_wr && !wb_req.dat[31] |=> !bus_enabled)
		else $error("enable not cleared");
	a_enable_hold: assert property (!set_wr |=> $stable(bus_enabled))
		else $error("enable changed without write");

	c_write_grant: cover property ($rose(write_ch0_grant));
	c_read_grant: cover property ($rose(read_ch0_grant));
	c_refused: cover property (set_wr && wb_req.dat[31] && !bus_enabled ##1 !bus_enabled);
endmodule

bind uda_arbiter uda_arbiter_checker chk_u (.mclk(mclk), .reset(reset), .ce(ce),
	.wb_req(wb_req), .wb_rsp(wb_rsp), .write_dma_channel_zero(write_dma_channel_zero),
	.read_dma_channel_zero(read_dma_channel_zero), .write_ch0_grant(write_ch0_grant),
	.read_ch0_grant(read_ch0_grant), .bus_enabled(bus_enabled));

// File: bench/uda_dma_model.sv
// Behavioural DMA channel that asks for the system bus for one access
`timescale 1ns/1ps
module uda_dma_model (
	input  wire logic              mclk,  // Bus clock
	input  wire logic              reset, // Async reset
	input  wire logic              start, // Pulse: begin one access
	input  wire logic [3:0]        hold,  // Extra owned cycles, 0 = prompt
	input  wire logic              grant, // Bus granted
	output uda_pkg::uda_chan_req_t chan,  // Request and done
	output logic                   busy   // Access pending
);
	logic [3:0] cnt_q;

	// Request stays up until the owned access ends; withdrawal and done share an edge
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			chan  <= '0;
			busy  <= 1'b0;
			cnt_q <= 4'h0;
		end else begin
			chan.done <= 1'b0;
			if (start && !busy) begin
				chan.req <= 1'b1;
				busy     <= 1'b1;
				cnt_q    <= hold;
			end else if (busy && grant && chan.req) begin
				if (cnt_q == 4'h0) begin
					chan.req  <= 1'b0;
					chan.done <= 1'b1;
					busy      <= 1'b0;
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
			end
		end
	end
endmodule

// File: bench/test_usb_dma_ahb_arbiter.sv
// Self-checking bench of the DMA bus arbiter
`timescale 1ns/1ps
`include "uda_map.svh"
module test_usb_dma_ahb_arbiter;
	logic                   mclk, reset, ce, gw, gr, en, st_w, st_r, bw, br;
	uda_pkg::uda_wb_req_t   wb_req;
	uda_pkg::uda_wb_rsp_t   wb_rsp;
	uda_pkg::uda_chan_req_t w_ch, r_ch;
	logic [3:0]             hold_w;
	logic [31:0]            rdat;
	int                     err_total, compares, n;

	uda_arbiter dut_u (.mclk(mclk), .reset(reset), .ce(ce), .wb_req(wb_req), .wb_rsp(wb_rsp),
		.write_dma_channel_zero(w_ch), .read_dma_channel_zero(r_ch),
		.write_ch0_grant(gw), .read_ch0_grant(gr), .bus_enabled(en));
	uda_dma_model wm_u (.mclk(mclk), .reset(reset), .start(st_w), .hold(hold_w),
		.grant(gw), .chan(w_ch), .busy(bw));
	uda_dma_model rm_u (.mclk(mclk), .reset(reset), .start(st_r), .hold(4'h2),
		.grant(gr), .chan(r_ch), .busy(br));

	// ------
	// Clock, reset and watchdog
	// ------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		wb_req = '0;
		st_w = 1'b0;
		st_r = 1'b0;
		hold_w = 4'h2;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
	end
	// Generous bound: the sequence needs well under two hundred cycles
	initial begin
		#50000;
		err_total++;
		end_sim();
	end

	// ------
	// Tasks
	// ------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Classic cycle held until ack is sampled, then one idle cycle; only the watchdog ends a wait
	task acc(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge mclk);
		wb_req <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'hf, dat:dat};
		do begin
			@(posedge mclk);
		end while (wb_rsp.ack !== 1'b1);
		rdat = wb_rsp.dat;
		wb_req <= '0;
	endtask
	task wr(input logic [31:0] d);
		acc(1'b1, `UDA_SETTING_OFS, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask
	// Start the chosen channels together; check who wins, then wait until neither is busy
	task race(input logic [1:0] go, input logic [1:0] exp);
		@(posedge mclk);
		st_w <= go[1];
		st_r <= go[0];
		@(posedge mclk);
		st_w <= 1'b0;
		st_r <= 1'b0;
		n = 0;
		while (!(gw || gr) && n < 20) begin
			@(posedge mclk);
			n++;
		end
		chk({30'h0, gw, gr}, {30'h0, exp});
		while ((bw || br) && n < 100) begin
			@(posedge mclk);
			n++;
		end
		chk({30'h0, bw, br}, 32'h0);
	endtask
	task end_sim;
		if (err_total == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ------
	// Main sequence
	// ------
	initial begin
		err_total = 0;
		compares = 0;
		repeat (6) @(posedge mclk);
		rd(`UDA_SETTING_OFS, 32'h0);
		rd(`UDA_STATUS_OFS, 32'h30);
		rd(8'h08, 32'h0);
		wr(32'h8000_0000);
		rd(`UDA_SETTING_OFS, 32'h0);
		rd(`UDA_STATUS_OFS, 32'h430);
		wr(32'h8000_1012);
		chk({31'h0, en}, 32'h0);
		// Request while disabled must wait
		st_w <= 1'b1;
		@(posedge mclk);
		st_w <= 1'b0;
		repeat (5) @(posedge mclk);
		chk({31'h0, gw}, 32'h0);
		wr(32'h7fff_ffff);
		rd(`UDA_SETTING_OFS, 32'h1000_3333);
		wr(32'h9000_3210);
		rd(`UDA_SETTING_OFS, 32'h9000_3210);
		chk({31'h0, gw}, 32'h1);
		wr(32'h8000_0123);
		rd(`UDA_SETTING_OFS, 32'h9000_3210);
		race(2'b11, 2'b01);
		wr(32'h1000_3210);
		wr(32'h9000_1032);
		race(2'b11, 2'b10);
		// Round-robin ignores that write has the top priority
		wr(32'h1000_1032);
		wr(32'h8000_1032);
		race(2'b11, 2'b10);
		race(2'b10, 2'b10);
		race(2'b11, 2'b01);
		// Clearing enable takes a live grant away while the request stays up
		hold_w <= 4'hf;
		@(posedge mclk);
		st_w <= 1'b1;
		@(posedge mclk);
		st_w <= 1'b0;
		repeat (2) @(posedge mclk);
		chk({31'h0, gw}, 32'h1);
		wr(32'h0000_1032);
		repeat (2) @(posedge mclk);
		chk({30'h0, gw, bw}, 32'h1);
		end_sim();
	end
endmodule
